// [rtl/bao_pkg.sv]
// constants and carrier types for the bit-op and add-skip decoder
package bao_pkg;

  // machine cycle timing: one instruction cycle of the core
  localparam int CLK_NS = 5;
  localparam int MC_NS = 20;
  localparam int MC_CLKS = MC_NS / CLK_NS;
  localparam logic [3:0] MC_LAST = 4'(MC_CLKS - 1);

  // first-byte opcodes handled here
  localparam logic [7:0] OPC_TST_T_C = 8'hD7;
  localparam logic [7:0] OPC_TST_T_MEM = 8'hF9;
  localparam logic [7:0] OPC_TST_F_MEM = 8'hF8;
  localparam logic [7:0] OPC_TST_CLR = 8'hFD;
  localparam logic [7:0] OPC_SET_MEM = 8'hFF;
  localparam logic [7:0] OPC_CLR_MEM = 8'hFE;
  localparam logic [7:0] OPC_AND = 8'hF5;
  localparam logic [7:0] OPC_OR = 8'hF6;
  localparam logic [7:0] OPC_XOR = 8'hF7;
  localparam logic [7:0] OPC_STC = 8'hFC;
  localparam logic [7:0] OPC_LDC = 8'hF4;
  localparam logic [7:0] OPC_ADC_A_HL = 8'h3E;
  localparam logic [7:0] OPC_ADS_A_HL = 8'h3F;
  localparam logic [7:0] OPC_ADS_EA_IMM = 8'hC9;
  localparam logic [7:0] OPC_PAIR_PFX = 8'hDC;
  localparam logic [3:0] ADS_IMM_HI = 4'hA;

  // direct bit form: 11bb00ff, ff selects the action
  localparam logic [1:0] DIR_HI = 2'h3;
  localparam logic [1:0] DIR_MID = 2'h0;
  localparam logic [1:0] DIR_TST_T = 2'h3;
  localparam logic [1:0] DIR_TST_F = 2'h2;
  localparam logic [1:0] DIR_SET = 2'h1;

  // second-byte sub-opcodes behind the pair prefix
  localparam logic [3:0] SUB_ADC = 4'hA;
  localparam logic [3:0] SUB_ADS = 4'h9;

  // bit operand second byte layouts
  localparam logic [7:0] HIO_PAGE_LO = 8'hFB;
  localparam logic [7:0] HIO_PAGE_HI = 8'hFF;
  localparam logic [3:0] IDX_TAG = 4'h4;
  localparam logic [5:0] IDX_PAGE = 6'h3F;

  // nibble slots of the working registers
  localparam logic [2:0] NIB_A = 3'h0;
  localparam logic [2:0] NIB_E = 3'h1;
  localparam logic [2:0] NIB_L = 3'h2;
  localparam logic [2:0] NIB_H = 3'h3;

  typedef enum logic [3:0] {
    OP_OTHER, OP_TST_T_C, OP_TST_T, OP_TST_F, OP_TST_CLR, OP_SET,
    OP_CLR, OP_AND, OP_OR, OP_XOR, OP_STC, OP_LDC, OP_ADC, OP_ADS
  } bao_op_type;

  typedef enum logic [2:0] {
    ADD_A_HL, ADD_A_IMM, ADD_EA_IMM, ADD_EA_RR, ADD_RR_EA
  } bao_kind_type;

  typedef enum logic [1:0] {S_IDLE, S_READ, S_CALC, S_HOLD} bao_st_type;

  typedef logic [7:0][3:0] bao_regs_type;

  typedef struct packed {
    logic valid;
    logic [7:0] b1;
    logic [7:0] b2;
  } bao_instr_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [3:0] wdata;
  } bao_mem_type;

  typedef struct packed {
    logic en;
    logic wide;
    logic [1:0] pair;
    logic [7:0] data;
  } bao_regwr_type;

  typedef struct packed {
    bao_op_type op;
    bao_kind_type kind;
    logic [11:0] addr;
    logic [1:0] bitSel;
    logic [1:0] cyc;
    logic needMem;
  } bao_dec_type;

endpackage

// [rtl/bao_mc_tick.sv]
// machine cycle enable: one-clock pulse every MC_CLKS clocks
`timescale 1ns/10ps
module bao_mc_tick
  import bao_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  output logic tick
);

  typedef struct packed {
    logic [3:0] cnt;
    logic tick;
  } bao_tick_state_type;

  bao_tick_state_type st_reg; // divider state
  bao_tick_state_type st_next; // its next value

  // count clocks and flag the last one of each machine cycle
  always_comb begin
    st_next = st_reg;
    st_next.tick = (st_reg.cnt == MC_LAST);
    st_next.cnt = (st_reg.cnt == MC_LAST) ? 4'h0 : st_reg.cnt + 4'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

endmodule

// [rtl/bao_decode_core.sv]
// decode and execute of bit ops, add-with-carry and add-then-skip
// How it works
// - test_true_skip skips when bit or carry set
// - test_false_skip skips when memory bit clear
// - test_clear_skip skips on one, clears bit
// - set bit, indexed address from operand and L
// - clear one bit, others untouched
// - carry becomes carry AND bit
// - carry becomes carry OR bit, source kept
// - carry becomes carry XOR bit
// - move_carry_bit store copies carry to bit
// - move_carry_bit load copies bit to carry
// - high I/O byte picks FBx or FFx page
// - add-with-carry sets carry on overflow only
// - add-with-carry one or two machine cycles
// - accumulator ADC overflow skips following add_then_skip A,#im
// - that following add_then_skip never skips itself
// - add_then_skip skips on overflow, carry untouched
`timescale 1ns/10ps
module bao_decode_core
  import bao_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input bao_instr_type instr,
  input wire logic [3:0] bank,
  input bao_regs_type regs,
  input wire logic [3:0] memRdData,
  output logic instrAck,
  output logic execOther,
  output bao_mem_type memReq,
  output bao_regwr_type regWr,
  output logic carry,
  output logic skipPending
);

  ////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    bao_st_type st;
    bao_op_type op;
    bao_kind_type kind;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [1:0] bitSel;
    logic [1:0] cyc; // machine cycles this instruction takes
    logic [1:0] cycCnt; // machine cycles already spent
    logic carry;
    logic skip; // next instruction is to be discarded
    logic squash; // current instruction is being discarded
    logic noSkip; // own skip inhibited after accumulator ADC
    logic adcFollow; // last instruction was ADC A,@HL
    logic adcOvf; // and it overflowed
    logic ack;
    logic other;
    bao_mem_type mem;
    bao_regwr_type rw;
  } bao_core_state_type;

  bao_core_state_type st_reg; // all state of the core
  bao_core_state_type st_next; // its next value

  logic tick; // one pulse per machine cycle
  bao_dec_type dec; // decode of the offered instruction
  logic accept; // instruction taken this clock
  logic adsImm; // offered instruction is ADD_THEN_SKIP A,#im
  logic curBit; // addressed bit of the returned nibble
  logic [3:0] bitMask; // one-hot of the addressed bit
  logic [7:0] eaVal; // wide accumulator value
  logic [7:0] pairVal; // register pair named by the second byte
  logic [7:0] addDst; // adder destination operand
  logic [7:0] addSrc; // adder source operand
  logic addCin; // carry into the adder
  logic [8:0] addSum; // adder result with carry out
  logic wideAdd; // eight-bit addition
  logic addOvf; // overflow out of the result's top bit

  // machine cycle divider; instructions start on its pulse
  bao_mc_tick u_tick (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////
  // decode

  // turn the two offered bytes into an operation and bit address
  function automatic bao_dec_type decode(
    input logic [7:0] b1,
    input logic [7:0] b2,
    input logic [3:0] bk,
    input logic [3:0] lo,
    input logic [3:0] hi
  );
    bao_dec_type d;
    d = '0;
    d.op = OP_OTHER;
    d.kind = ADD_A_HL;
    d.cyc = 2'd1;
    // second byte of the F-prefixed bit forms
    if (b2[7]) begin
      // high I/O page picked by the second leading bit
      d.addr = {(b2[6] ? HIO_PAGE_HI : HIO_PAGE_LO), b2[3:0]};
      d.bitSel = b2[5:4];
    end else if (b2[7:4] == IDX_TAG) begin
      // indexed: operand bits plus L.3-2, bit from L.1-0
      d.addr = {IDX_PAGE, b2[3:0], lo[3:2]};
      d.bitSel = lo[1:0];
    end else begin
      // pointer plus offset: H joined with the low operand nibble
      d.addr = {bk, hi, b2[3:0]};
      d.bitSel = b2[5:4];
    end
    case (b1)
      OPC_TST_T_C: begin
        d.op = OP_TST_T_C;
      end
      OPC_TST_T_MEM: d.op = OP_TST_T;
      OPC_TST_F_MEM: d.op = OP_TST_F;
      OPC_TST_CLR: d.op = OP_TST_CLR;
      OPC_SET_MEM: d.op = OP_SET;
      OPC_CLR_MEM: d.op = OP_CLR;
      OPC_AND: d.op = OP_AND;
      OPC_OR: d.op = OP_OR;
      OPC_XOR: d.op = OP_XOR;
      OPC_STC: d.op = OP_STC;
      OPC_LDC: d.op = OP_LDC;
      OPC_ADC_A_HL: begin
        d.op = OP_ADC;
        d.addr = {bk, hi, lo};
      end
      OPC_ADS_A_HL: begin
        d.op = OP_ADS;
        d.addr = {bk, hi, lo};
      end
      OPC_ADS_EA_IMM: begin
        d.op = OP_ADS;
        d.kind = ADD_EA_IMM;
        d.cyc = 2'd2;
      end
      OPC_PAIR_PFX: begin
        // only even pair codes exist behind the prefix
        if (!b2[0] && (b2[7:4] == SUB_ADC || b2[7:4] == SUB_ADS)) begin
          d.op = (b2[7:4] == SUB_ADC) ? OP_ADC : OP_ADS;
          d.kind = b2[3] ? ADD_EA_RR : ADD_RR_EA;
          d.cyc = 2'd2;
        end
      end
      default: begin
        if (b1[7:4] == ADS_IMM_HI) begin
          d.op = OP_ADS;
          d.kind = ADD_A_IMM;
        end else if (b1[7:6] == DIR_HI && b1[3:2] == DIR_MID) begin
          // direct form: bank page, full address byte in b2
          d.addr = {bk, b2};
          d.bitSel = b1[5:4];
          case (b1[1:0])
            DIR_TST_T: d.op = OP_TST_T;
            DIR_TST_F: d.op = OP_TST_F;
            DIR_SET: d.op = OP_SET;
            default: d.op = OP_CLR;
          endcase
        end
      end
    endcase
    // all memory bit forms take two machine cycles
    if (d.op inside {[OP_TST_T:OP_LDC]}) begin
      d.cyc = 2'd2;
      d.needMem = 1'b1;
    end
    if ((d.op == OP_ADC || d.op == OP_ADS) && d.kind == ADD_A_HL) begin
      d.needMem = 1'b1;
    end
    return d;
  endfunction

  assign dec = decode(instr.b1, instr.b2, bank, regs[NIB_L], regs[NIB_H]);
  assign accept = (st_reg.st == S_IDLE) && instr.valid && tick;
  assign adsImm = (dec.op == OP_ADS) && (dec.kind == ADD_A_IMM);

  ////////////////////////////////////////////////////////////////////
  // datapath helpers

  assign curBit = memRdData[st_reg.bitSel];
  assign bitMask = 4'h1 << st_reg.bitSel;
  assign eaVal = {regs[NIB_E], regs[NIB_A]};
  assign pairVal = {regs[{st_reg.b2[2:1], 1'b1}],
                    regs[{st_reg.b2[2:1], 1'b0}]};

  // operands by form; narrow forms sit in the low nibble
  assign addDst = (st_reg.kind == ADD_A_HL || st_reg.kind == ADD_A_IMM)
                  ? {4'h0, regs[NIB_A]}
                  : (st_reg.kind == ADD_RR_EA) ? pairVal : eaVal;
  assign addSrc = (st_reg.kind == ADD_A_HL) ? {4'h0, memRdData}
                : (st_reg.kind == ADD_A_IMM) ? {4'h0, st_reg.b1[3:0]}
                : (st_reg.kind == ADD_EA_IMM) ? st_reg.b2
                : (st_reg.kind == ADD_EA_RR) ? pairVal : eaVal;
  assign addCin = (st_reg.op == OP_ADC) && st_reg.carry;
  assign addSum = {1'b0, addDst} + {1'b0, addSrc} + {8'h00, addCin};
  assign wideAdd = (st_reg.kind != ADD_A_HL) &&
                   (st_reg.kind != ADD_A_IMM);
  // overflow is the carry out just above the top bit of the result width
  assign addOvf = wideAdd ? addSum[8] : addSum[4];

  ////////////////////////////////////////////////////////////////////
  // sequencer

  // accept, read, execute, then wait out the machine cycles
  always_comb begin
    st_next = st_reg;
    // strobes are one-clock pulses
    st_next.ack = 1'b0;
    st_next.other = 1'b0;
    st_next.mem.rd = 1'b0;
    st_next.mem.wr = 1'b0;
    st_next.rw.en = 1'b0;
    case (st_reg.st)
      S_IDLE: begin
        if (accept) begin
          st_next.op = dec.op;
          st_next.kind = dec.kind;
          st_next.b1 = instr.b1;
          st_next.b2 = instr.b2;
          st_next.bitSel = dec.bitSel;
          st_next.cyc = dec.cyc;
          st_next.cycCnt = 2'd0;
          st_next.mem.addr = dec.addr;
          st_next.noSkip = 1'b0;
          st_next.adcFollow = 1'b0;
          st_next.squash = 1'b0;
          if (st_reg.skip) begin
            // fetched but discarded
            st_next.squash = 1'b1;
            st_next.skip = 1'b0;
          end else if (st_reg.adcFollow && adsImm) begin
            // decimal adjust pairing
            st_next.squash = st_reg.adcOvf;
            // its own overflow may not skip
            st_next.noSkip = 1'b1;
          end
          if (st_next.squash || dec.op == OP_OTHER) begin
            // foreign opcodes run elsewhere unless discarded
            st_next.other = !st_next.squash && dec.op == OP_OTHER;
            st_next.st = S_HOLD;
          end else if (dec.needMem) begin
            st_next.mem.rd = 1'b1;
            st_next.st = S_READ;
          end else begin
            st_next.st = S_CALC;
          end
        end
      end
      S_READ: begin
        // memory answers one clock after the read strobe
        st_next.st = S_CALC;
      end
      S_CALC: begin
        st_next.st = S_HOLD;
        case (st_reg.op)
          OP_TST_T_C: st_next.skip = st_reg.carry;
          OP_TST_T: st_next.skip = curBit;
          OP_TST_F: st_next.skip = !curBit;
          OP_TST_CLR: begin
            // skip on one and write the bit back as zero
            st_next.skip = curBit;
            st_next.mem.wr = 1'b1;
            st_next.mem.wdata = memRdData & ~bitMask;
          end
          OP_SET: begin
            // read-modify-write keeps the other three bits
            st_next.mem.wr = 1'b1;
            st_next.mem.wdata = memRdData | bitMask;
          end
          OP_CLR: begin
            st_next.mem.wr = 1'b1;
            st_next.mem.wdata = memRdData & ~bitMask;
          end
          OP_AND: st_next.carry = st_reg.carry & curBit;
          OP_OR: st_next.carry = st_reg.carry | curBit;
          OP_XOR: st_next.carry = st_reg.carry ^ curBit;
          OP_STC: begin
            st_next.mem.wr = 1'b1;
            st_next.mem.wdata = (memRdData & ~bitMask) |
                                (st_reg.carry ? bitMask : 4'h0);
          end
          OP_LDC: st_next.carry = curBit;
          OP_ADC, OP_ADS: begin
            // source untouched, only destination written back
            st_next.rw.en = 1'b1;
            st_next.rw.wide = wideAdd;
            st_next.rw.pair = (st_reg.kind == ADD_RR_EA)
                              ? st_reg.b2[2:1] : 2'd0;
            st_next.rw.data = wideAdd ? addSum[7:0]
                                      : {4'h0, addSum[3:0]};
            if (st_reg.op == OP_ADC) begin
              st_next.carry = addOvf;
              if (st_reg.kind == ADD_A_HL) begin
                // remember overflow for a following ADD_THEN_SKIP
                st_next.adcFollow = 1'b1;
                st_next.adcOvf = addOvf;
              end
            end else if (!st_reg.noSkip) begin
              st_next.skip = addOvf; // carry left alone
            end
          end
          default: begin
          end
        endcase
      end
      S_HOLD: begin
        // finish on the last machine cycle boundary
        if (tick) begin
          if (st_reg.cycCnt + 2'd1 == st_reg.cyc) begin
            st_next.ack = 1'b1;
            st_next.st = S_IDLE;
          end else begin
            st_next.cycCnt = st_reg.cycCnt + 2'd1;
          end
        end
      end
      default: st_next.st = S_IDLE;
    endcase
  end

  // one register for the whole state; reset clears every flag
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign instrAck = st_reg.ack;
  assign execOther = st_reg.other;
  assign memReq = st_reg.mem;
  assign regWr = st_reg.rw;
  assign carry = st_reg.carry;
  assign skipPending = st_reg.skip;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  logic inCalc; // execute clock
  assign inCalc = (st_reg.st == S_CALC);

  sequence oneMc;
    ##1 (!instrAck)[*4] ##1 instrAck;
  endsequence

  sequence twoMc;
    ##1 (!instrAck)[*8] ##1 instrAck;
  endsequence

  tst_true_a: assert property (
    inCalc && st_reg.op == OP_TST_T |=> skipPending == $past(curBit))
    else $error("true test skip wrong");
  tst_false_a: assert property (
    inCalc && st_reg.op == OP_TST_F |=> skipPending == !$past(curBit))
    else $error("false test skip wrong");
  tst_clear_a: assert property (
    inCalc && st_reg.op == OP_TST_CLR |=> memReq.wr &&
    !memReq.wdata[st_reg.bitSel] && skipPending == $past(curBit))
    else $error("test and clear wrong");
  set_bit_a: assert property (
    inCalc && st_reg.op == OP_SET |=> memReq.wr &&
    memReq.wdata == $past(memRdData | bitMask))
    else $error("bit set wrong");
  clear_bit_a: assert property (
    inCalc && st_reg.op == OP_CLR |=> memReq.wr &&
    memReq.wdata == $past(memRdData & ~bitMask))
    else $error("bit clear wrong");
  carry_and_a: assert property (
    inCalc && st_reg.op == OP_AND |=> carry == $past(carry & curBit))
    else $error("carry and wrong");
  carry_or_a: assert property (
    inCalc && st_reg.op == OP_OR |=> carry == $past(carry | curBit) &&
    !memReq.wr)
    else $error("carry or wrong");
  carry_xor_a: assert property (
    inCalc && st_reg.op == OP_XOR |=> carry == $past(carry ^ curBit))
    else $error("carry xor wrong");
  store_carry_a: assert property (
    inCalc && st_reg.op == OP_STC |=> memReq.wr &&
    memReq.wdata[st_reg.bitSel] == $past(carry))
    else $error("carry store wrong");
  load_carry_a: assert property (
    inCalc && st_reg.op == OP_LDC |=> carry == $past(curBit))
    else $error("carry load wrong");
  high_io_a: assert property (
    accept && instr.b1[7:4] == 4'hF && instr.b1[3:2] != DIR_MID &&
    instr.b2[7] && dec.op != OP_OTHER |=>
    memReq.addr[3:0] == $past(instr.b2[3:0]) &&
    memReq.addr[11:4] == ($past(instr.b2[6]) ? 8'hFF : 8'hFB))
    else $error("high io decode wrong");
  adc_carry_a: assert property (
    inCalc && st_reg.op == OP_ADC |=> carry == $past(addOvf) &&
    regWr.en)
    else $error("add carry wrong");
  adc_short_a: assert property (
    accept && !skipPending && dec.op == OP_ADC &&
    dec.kind == ADD_A_HL |-> oneMc)
    else $error("short add timing wrong");
  adc_long_a: assert property (
    accept && !skipPending && dec.op == OP_ADC &&
    dec.kind != ADD_A_HL |-> twoMc)
    else $error("pair add timing wrong");
  adc_pair_a: assert property (
    accept && adsImm && !skipPending && st_reg.adcFollow |=>
    st_reg.squash == $past(st_reg.adcOvf))
    else $error("adjust skip wrong");
  ads_inhibit_a: assert property (
    accept && adsImm && !skipPending && st_reg.adcFollow |=>
    (!skipPending)[*5])
    else $error("inhibited add skipped");
  ads_skip_a: assert property (
    inCalc && st_reg.op == OP_ADS && !st_reg.noSkip |=>
    skipPending == $past(addOvf) && $stable(carry))
    else $error("add skip wrong");
  squash_a: assert property (
    st_reg.squash |-> !memReq.wr && !regWr.en && !execOther &&
    $stable(carry))
    else $error("skipped instruction had effect");

endmodule

// [dv/bao_decode_core_tb.sv]
// self-checking bench for the bit-op and add-skip decoder
`timescale 1ns/10ps
module bao_decode_core_tb
  import bao_pkg::*;
();
  ////////////////////////////////////////////////////////////////////
  // stimulus and observed ports
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1; // held for the first 12 clocks
  bao_instr_type instr = '0;
  logic [3:0] bank = 4'h0;
  bao_regs_type regs = '0;
  logic [3:0] memRdData = 4'h0;
  logic instrAck, execOther, carry, skipPending;
  bao_mem_type memReq;
  bao_regwr_type regWr;
  logic [3:0] mem [0:4095]; // data memory model, one nibble a place
  logic [7:0] rwData; // last value written to the registers
  int error_cnt = 0, checks_done = 0;
  int cyc = 0, lastAck = 0, gapCyc = 0; // ack-to-ack spacing
  int wrN = 0, exN = 0, rwN = 0; // strobe counts

  bao_decode_core u_bao_decode_core (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .instr(instr), .bank(bank),
    .regs(regs), .memRdData(memRdData), .instrAck(instrAck),
    .execOther(execOther), .memReq(memReq), .regWr(regWr),
    .carry(carry), .skipPending(skipPending));

  // 200 MHz core clock
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // count strobes on the rising edge; writes land in the model
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (memReq.wr === 1'b1) begin
      mem[memReq.addr] <= memReq.wdata;
      wrN <= wrN + 1;
    end
    if (regWr.en === 1'b1) begin
      rwN <= rwN + 1;
      rwData <= regWr.data;
    end
    if (execOther === 1'b1) exN <= exN + 1;
  end

  // memory answers half a clock after the read, ahead of sampling
  always @(negedge clk_sys) memRdData = mem[memReq.addr];

  ////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask

  // present one instruction, wait for its ack; valid stays up so the
  // caller replaces or drops it in this same falling edge
  task automatic run(input logic [7:0] b1, input logic [7:0] b2);
    int n;
    n = 0;
    instr = '{1'b1, b1, b2};
    do begin
      @(negedge clk_sys);
      n++;
    end while (instrAck !== 1'b1 && n < 40);
    chk(16'(instrAck), 16'h0001);
    gapCyc = cyc - lastAck;
    lastAck = cyc;
  endtask

  // drop the request and let the core sit idle
  task automatic rest();
    instr.valid = 1'b0;
    repeat (8) @(negedge clk_sys);
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // scenarios
  // carry logic with high i/o bits on both pages
  task automatic t_carry();
    int e;
    mem[12'hFF5] = 4'h4;
    mem[12'hFB5] = 4'h4;
    run(OPC_TST_T_C, 8'h00);
    chk(skipPending, 1'b0);
    run(OPC_OR, 8'hE5);
    chk(carry, 1'b1);
    chk(memReq.addr, 12'hFF5);
    chk(mem[12'hFF5], 4'h4);
    run(OPC_TST_T_C, 8'h00);
    chk(skipPending, 1'b1);
    chk(16'(gapCyc), 16'd8);
    e = exN;
    run(8'h00, 8'h00);
    chk(16'(exN - e), 16'd0);
    run(OPC_AND, 8'hC5);
    chk(carry, 1'b0);
    run(OPC_XOR, 8'hA5);
    chk(carry, 1'b1);
    chk(memReq.addr, 12'hFB5);
    e = exN;
    run(8'h00, 8'h00);
    chk(16'(exN - e), 16'd1);
    rest();
  endtask

  // set through the indexed form, clear through the direct form
  task automatic t_setclr();
    regs[2] = 4'hB;
    bank = 4'h2;
    mem[12'hFEA] = 4'h1;
    mem[12'h234] = 4'hF;
    run(OPC_SET_MEM, 8'h4A);
    chk(mem[12'hFEA], 4'h9);
    run(8'hD0, 8'h34);
    chk(mem[12'h234], 4'hD);
    chk(16'(gapCyc), 16'd12);
    rest();
  endtask

  // memory bit tests; the skipped one must leave no trace
  task automatic t_skip();
    int w;
    bank = 4'h1;
    regs[3] = 4'h3;
    regs[2] = 4'h6;
    mem[12'h137] = 4'hE;
    mem[12'hFD5] = 4'h4;
    mem[12'h120] = 4'h4;
    run(OPC_TST_F_MEM, 8'h07);
    chk(skipPending, 1'b1);
    w = wrN;
    run(8'hD1, 8'h37);
    chk(16'(wrN - w), 16'd0);
    chk(mem[12'h137], 4'hE);
    chk(16'(gapCyc), 16'd12);
    run(OPC_TST_CLR, 8'h45);
    chk(skipPending, 1'b1);
    chk(mem[12'hFD5], 4'h0);
    run(8'hE3, 8'h20);
    chk(skipPending, 1'b0);
    run(8'hE3, 8'h20);
    chk(skipPending, 1'b1);
    run(8'h00, 8'h00);
    chk(skipPending, 1'b0);
    rest();
  endtask

  // carry to bit and back, pointer-plus-offset form
  task automatic t_move();
    bank = 4'h0;
    regs[3] = 4'h5;
    mem[12'h052] = 4'h0;
    mem[12'h053] = 4'hB;
    run(OPC_STC, 8'h72);
    chk(mem[12'h052], 4'h8);
    run(OPC_LDC, 8'h23);
    chk(carry, 1'b0);
    rest();
  endtask

  // additions and the decimal-adjust skip pairing
  task automatic t_add();
    int r;
    regs = '0;
    regs[0] = 4'h9;
    regs[2] = 4'h8;
    mem[12'h008] = 4'h4;
    mem[12'h0AA] = 4'h9;
    run(OPC_ADC_A_HL, 8'h00);
    chk(rwData[3:0], 4'hD);
    chk({carry, skipPending}, 2'b00);
    regs[0] = 4'hD;
    run({ADS_IMM_HI, 4'hA}, 8'h00);
    chk(rwData[3:0], 4'h7);
    chk({carry, skipPending}, 2'b00);
    chk(16'(gapCyc), 16'd8);
    regs = 32'h0000AAC3;
    run(OPC_PAIR_PFX, 8'hAA);
    chk(rwData, 8'h6D);
    chk(carry, 1'b1);
    chk(16'(gapCyc), 16'd12);
    regs[0] = 4'hE;
    run(OPC_ADC_A_HL, 8'h00);
    chk(rwData[3:0], 4'h8);
    chk({carry, skipPending}, 2'b10);
    chk(16'(gapCyc), 16'd8);
    r = rwN;
    run({ADS_IMM_HI, 4'hA}, 8'h00);
    chk(16'(rwN - r), 16'd0);
    regs[0] = 4'hF;
    run({ADS_IMM_HI, 4'h1}, 8'h00);
    chk(rwData[3:0], 4'h0);
    chk({carry, skipPending}, 2'b11);
    run(8'h00, 8'h00);
    chk(skipPending, 1'b0);
    rest();
  endtask

  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    foreach (mem[i]) mem[i] = 4'h0;
    repeat (12) @(negedge clk_sys);
    sys_rst = 1'b0;
    @(negedge clk_sys);
    chk({instrAck, execOther, carry, skipPending, memReq.rd,
      memReq.wr, regWr.en}, 16'h0000);
    t_carry();
    t_setclr();
    t_skip();
    t_move();
    t_add();
    print_verdict();
  end

  // watchdog: the whole run needs well under 2000 clocks
  initial begin
    #20000;
    error_cnt++;
    print_verdict();
  end
endmodule
